// ### logic/gdf_fault_prot.sv
// Fault supervision and gate response logic with an APB register slave
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
module gdf_fault_prot #(
   parameter int unsigned MS_CYC = gdf_pkg::MS_CYC_DFLT  // Cycles per ms
) (
   // Clock and reset
   input  wire logic                     core_clk,
   input  wire logic                     rst_n,
   // APB slave
   input  wire logic [7:0]               paddr,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [31:0]              pwdata,
   output      logic                     pready,
   output      logic [31:0]              prdata,
   output      logic                     pslverr,
   // Analog comparator flags, asynchronous
   input  wire gdf_pkg::gdf_pins_t       pins_in,
   // Gate commands from the modulator, same clock
   input  wire logic [gdf_pkg::NPH-1:0]  pwm_hi,
   input  wire logic [gdf_pkg::NPH-1:0]  pwm_lo,
   // Gate driver and supply controls
   output      logic [gdf_pkg::NPH-1:0]  gate_hi,
   output      logic [gdf_pkg::NPH-1:0]  gate_lo,
   output      logic                     charge_pump_en,
   output      logic                     logic_en,
   output      logic                     fault_out_n,
   // Analog threshold selects
   output      logic [3:0]               drain_source_level_sel,
   output      logic [3:0]               hw_current_limit_threshold
);
   import gdf_pkg::*;

   //---------------------------------------------------------------------
   // Helpers
   //---------------------------------------------------------------------

   // Decode of the four-bit current-limit mode field
   function automatic gdf_il_t il_class(input logic [3:0] m);
      gdf_il_t c;
      c = IL_NONE;
      if (m[3]) begin
         c = (m[2:0] == 3'b000) ? IL_REPORT : IL_NONE;
      end else begin
         c = m[1] ? IL_LOW_ON : IL_OFF;
      end
      return c;
   endfunction : il_class

   // Retry flavour of the mode field (01xxb)
   function automatic logic il_retry(input logic [3:0] m);
      return (m[3:2] == 2'b01);
   endfunction : il_retry

   localparam int unsigned MSW = $clog2(MS_CYC + 1);
   localparam int unsigned USW = $clog2(US_CYC + 1);

   //---------------------------------------------------------------------
   // Declarations
   //---------------------------------------------------------------------
   gdf_pins_t        sync1_q;      // First synchroniser stage
   gdf_pins_t        sync2_q;      // Second stage, safe to use
   gdf_cfg_t         cfg_q;        // Configuration register
   logic             clr_q;        // One-cycle clear command
   logic             pready_q;     // Access phase answer
   logic [31:0]      prdata_q;     // Read data
   logic             pslverr_q;    // Unmapped address error
   logic [MSW-1:0]   ms_pre_q;     // Millisecond prescaler
   logic             ms_tick;      // One cycle per ms
   logic [USW-1:0]   us_pre_q;     // Microsecond prescaler
   logic             us_tick;      // One cycle per us
   logic [7:0]       deg_q;        // Limit deglitch count in us
   logic             il_qual_q;    // Limit comparator qualified
   logic [3:0]       lat_q;        // Gate, boot, ds, shunt latches
   logic [3:0]       cond;         // Live qualified conditions
   logic [3:0]       rsel;         // Retry selects per latch
   logic             ot_q;         // Overtemperature latch
   logic             il_q;         // Current-limit event pending
   gdf_il_t          il_act_q;     // Response held for the event
   logic             il_rtry_q;    // Event uses the retry path
   gdf_rt_t          rt_q;         // Retry timer state
   logic [15:0]      rt_cnt_q;     // Remaining retry ms
   logic             rt_done;      // Retry period expired
   logic             rt_elig;      // Something waits for retry
   logic             main_uv;      // Main supply low
   logic             por;          // Logic supply low
   logic             shut;         // All gates forced low
   logic             low_on;       // Low sides forced on
   logic             pend;         // Any reported fault
   logic [NPH-1:0]   hi_q;         // Gate high-side outputs
   logic [NPH-1:0]   lo_q;         // Gate low-side outputs
   logic             pump_q;       // Charge pump enable
   logic             lgc_q;        // Internal logic enable
   logic             fault_n_q;    // Active-low fault pin
   gdf_flt_t         gsta;         // Gate-driver status view
   logic             apb_wr;       // Completing write
   logic             apb_setup;    // Setup phase seen

   //---------------------------------------------------------------------
   // Input synchroniser
   //---------------------------------------------------------------------

   // Two flops per flag; only the second stage feeds logic
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= pins_in;
         sync2_q <= sync1_q;
      end
   end

   // Qualified conditions; disable bits suppress detection
   assign main_uv = sync2_q.main_supply_uv;
   assign por     = sync2_q.logic_supply_por;
   assign cond[0] = sync2_q.gate_supply_uv;
   assign cond[1] = (|sync2_q.bootstrap_uv)
                    & ~cfg_q.bootstrap_fault_disable;
   assign cond[2] = (|sync2_q.drain_source_hs
                    | |sync2_q.drain_source_ls)
                    & ~cfg_q.drain_source_fault_disable;
   assign cond[3] = sync2_q.shunt_oc
                    & ~cfg_q.shunt_fault_disable;
   assign rsel    = {cfg_q.shunt_retry_sel,
                     cfg_q.drain_source_retry_sel,
                     cfg_q.bootstrap_uv_retry_sel,
                     cfg_q.gate_supply_uv_retry_sel};

   //---------------------------------------------------------------------
   // APB slave
   //---------------------------------------------------------------------
   assign apb_setup = psel & ~penable;
   assign apb_wr    = psel & penable & pready_q & pwrite;

   // Answer is prepared in setup so access completes in one cycle
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready_q  <= 1'b0;
         prdata_q  <= '0;
         pslverr_q <= 1'b0;
      end else if (apb_setup) begin
         pready_q  <= 1'b1;
         pslverr_q <= 1'b0;
         prdata_q  <= '0;
         unique case (paddr)
            CFG_OFS:  prdata_q <= cfg_q;
            CMD_OFS:  prdata_q <= '0;   // Command bits self-clear
            GSTA_OFS: prdata_q <= {25'h000_0000, gsta};
            CSTA_OFS: prdata_q <= {30'h0000_0000, il_q, il_q};
            default:  pslverr_q <= 1'b1;
         endcase
      end else begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end
   end

   // Configuration register; reserved bits stay zero
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q <= CFG_RST;
      end else if (apb_wr && paddr == CFG_OFS) begin
         cfg_q <= pwdata & CFG_WMASK;
      end
   end

   // Clear command: a single pulse per write, never held
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         clr_q <= 1'b0;
      end else begin
         clr_q <= apb_wr && paddr == CMD_OFS && pwdata[CLR_BIT];
      end
   end

   //---------------------------------------------------------------------
   // Time bases
   //---------------------------------------------------------------------
   assign ms_tick = (ms_pre_q == MSW'(MS_CYC - 1));
   assign us_tick = (us_pre_q == USW'(US_CYC - 1));

   // Free-running prescalers; retry resolution is one ms
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ms_pre_q <= '0;
         us_pre_q <= '0;
      end else begin
         ms_pre_q <= ms_tick ? '0 : ms_pre_q + MSW'(1);
         us_pre_q <= us_tick ? '0 : us_pre_q + USW'(1);
      end
   end

   //---------------------------------------------------------------------
   // Current-limit deglitch
   //---------------------------------------------------------------------

   // Comparator must stay high for the selected time; a drop restarts
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         deg_q     <= '0;
         il_qual_q <= 1'b0;
      end else if (!sync2_q.hw_limit_cmp) begin
         deg_q     <= '0;
         il_qual_q <= 1'b0;
      end else if (deg_q >= DEG_US[cfg_q.hw_current_limit_deglitch]) begin
         il_qual_q <= 1'b1;
      end else if (us_tick) begin
         deg_q <= deg_q + 8'h01;
      end
   end

   //---------------------------------------------------------------------
   // Retry timer
   //---------------------------------------------------------------------

   // Waits while any retry-mode fault has cleared or a limit retries
   assign rt_elig = (|(lat_q & rsel & ~cond)) | (il_q & il_rtry_q);
   assign rt_done = (rt_q == RT_RUN) && ms_tick && (rt_cnt_q == '0);

   // Restarts whenever nothing waits, so the first fault to wait gets the full time
   // A fault that joins a running timer shares its remaining time
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rt_q     <= RT_IDLE;
         rt_cnt_q <= '0;
      end else begin
         unique case (rt_q)
            RT_IDLE: begin
               if (rt_elig) begin
                  rt_q     <= RT_RUN;
                  rt_cnt_q <= RETRY_MS[cfg_q.retry_time_sel] - 16'h0001;
               end
            end
            RT_RUN: begin
               if (!rt_elig || rt_done) begin
                  rt_q <= RT_IDLE;
               end else if (ms_tick) begin
                  rt_cnt_q <= rt_cnt_q - 16'h0001;
               end
            end
         endcase
      end
   end

   //---------------------------------------------------------------------
   // Fault latches
   //---------------------------------------------------------------------

   // Gate, bootstrap, drain-source and shunt share one recovery scheme
   for (genvar i = 0; i < 4; i++) begin : g_lat
      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            lat_q[i] <= 1'b0;
         end else if (por) begin
            lat_q[i] <= 1'b0;             // Logic held inactive
         end else if (cond[i]) begin
            lat_q[i] <= 1'b1;             // Set wins over the clear command and retry expiry; por still wins over set
         end else if (rsel[i] ? rt_done : clr_q) begin
            lat_q[i] <= 1'b0;
         end
      end
   end

   // Overtemperature: automatic or needs the clear command
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ot_q <= 1'b0;
      end else if (por) begin
         ot_q <= 1'b0;
      end else if (sync2_q.overtemp_shutdown) begin
         ot_q <= 1'b1;
      end else if (cfg_q.overtemp_auto_recover || clr_q) begin
         ot_q <= 1'b0;
      end
   end

   // Current-limit event; response is frozen at the event
   // A comparator still high after the retry time sets it again
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         il_q      <= 1'b0;
         il_act_q  <= IL_NONE;
         il_rtry_q <= 1'b0;
      end else if (por) begin
         il_q      <= 1'b0;
         il_act_q  <= IL_NONE;
      end else if (il_qual_q
                   && il_class(cfg_q.hw_current_limit_response) != IL_NONE)
      begin
         il_q      <= 1'b1;
         il_act_q  <= il_class(cfg_q.hw_current_limit_response);
         il_rtry_q <= il_retry(cfg_q.hw_current_limit_response);
      end else if (il_q && il_rtry_q && rt_done) begin
         il_q      <= 1'b0;
      end else if (il_q && !il_rtry_q && clr_q
                   && !sync2_q.hw_limit_cmp) begin
         il_q      <= 1'b0;
      end
   end

   //---------------------------------------------------------------------
   // Response and outputs
   //---------------------------------------------------------------------

   // Report-only events leave the gates alone
   assign shut   = main_uv | por | (|lat_q) | ot_q
                   | (il_q && il_act_q == IL_OFF);
   assign low_on = il_q && il_act_q == IL_LOW_ON;
   assign pend   = main_uv | por | (|lat_q) | ot_q | il_q;

   assign gsta = '{main_uv:   main_uv,
                   logic_por: por,
                   gate_uv:   lat_q[0],
                   boot_uv:   lat_q[1],
                   ds_oc:     lat_q[2],
                   shunt_oc:  lat_q[3],
                   overtemp:  ot_q};

   // Gate drive: shutdown beats low-side clamp beats modulator;
   // reporting takes a few cycles, well inside the allowed latency
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hi_q <= '0;
         lo_q <= '0;
      end else if (shut) begin
         hi_q <= '0;
         lo_q <= '0;
      end else if (low_on) begin
         hi_q <= '0;
         lo_q <= '1;
      end else begin
         hi_q <= pwm_hi;
         lo_q <= pwm_lo;
      end
   end

   // Supplies follow the live supply flags with no clear needed
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pump_q <= 1'b0;
         lgc_q  <= 1'b0;
      end else begin
         pump_q <= ~(main_uv | por);
         lgc_q  <= ~(main_uv | por);
      end
   end

   // Fault pin low while anything is pending
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fault_n_q <= 1'b1;
      end else begin
         fault_n_q <= ~pend;
      end
   end

   // Every port is a flop or a stored field; no logic on the way out
   assign pready                     = pready_q;
   assign prdata                     = prdata_q;
   assign pslverr                    = pslverr_q;
   assign gate_hi                    = hi_q;
   assign gate_lo                    = lo_q;
   assign charge_pump_en             = pump_q;
   assign logic_en                   = lgc_q;
   assign fault_out_n                = fault_n_q;
   assign drain_source_level_sel     = cfg_q.drain_source_level_sel;
   assign hw_current_limit_threshold = cfg_q.hw_current_limit_threshold;

endmodule : gdf_fault_prot

// ### logic/gdf_pkg.sv
// Package: register map, field layouts, timing and types of the fault block
//------------------------------------------------------------------------
// How it works
// - Faults reported within 200 ms
// - Main supply low: gates, pump, logic off
// - Main supply recovery is automatic
// - Logic supply low: everything off, restart after
// - Gate supply low: gates off, pump runs
// - Gate supply: clear command or retry time
// - Bootstrap low: gates off unless disabled
// - Bootstrap: clear command or retry time
// - Drain-source overcurrent: gates off unless disabled
// - Drain-source: clear command or retry time
// - Shunt overcurrent: gates off unless disabled
// - Shunt: clear command or retry time
// - Overtemp: gates off, latched or automatic
// - Current limit qualified by configured deglitch
// - Latched limit: all off or lows on
// - Retry limit: all off or lows on
// - Latched limit sets flags, clear command releases
// - Retry limit clears flags after retry time
// - Report-only limit: flags, fault, gates run
// - Report-only holds until clear and command
// - Modes 1001b-1111b ignore current limit
//------------------------------------------------------------------------
package gdf_pkg;

   // Phase count of the bridge
   localparam int unsigned NPH = 3;

   // Register byte offsets on the bus
   localparam logic [7:0] CFG_OFS  = 8'h00;
   localparam logic [7:0] CMD_OFS  = 8'h04;
   localparam logic [7:0] GSTA_OFS = 8'h08;
   localparam logic [7:0] CSTA_OFS = 8'h0C;

   // Reset value: all latched, limit response ignored
   localparam logic [31:0] CFG_RST   = 32'h0000_9000;
   // Writable configuration bits, reserved bits stay zero
   localparam logic [31:0] CFG_WMASK = 32'h077F_FFFF;
   // Clear-fault bit position in the command word
   localparam int unsigned CLR_BIT   = 0;

   // Configuration word layout
   typedef struct packed {
      logic [4:0] rsv1;
      logic [2:0] retry_time_sel;
      logic       rsv0;
      logic [2:0] hw_current_limit_deglitch;
      logic [3:0] hw_current_limit_threshold;
      logic [3:0] hw_current_limit_response;
      logic [3:0] drain_source_level_sel;
      logic       overtemp_auto_recover;
      logic       shunt_retry_sel;
      logic       shunt_fault_disable;
      logic       drain_source_retry_sel;
      logic       drain_source_fault_disable;
      logic       bootstrap_fault_disable;
      logic       bootstrap_uv_retry_sel;
      logic       gate_supply_uv_retry_sel;
   } gdf_cfg_t;

   // Comparator flags arriving from the analog side
   typedef struct packed {
      logic           main_supply_uv;
      logic           logic_supply_por;
      logic           gate_supply_uv;
      logic [NPH-1:0] bootstrap_uv;
      logic [NPH-1:0] drain_source_hs;
      logic [NPH-1:0] drain_source_ls;
      logic           shunt_oc;
      logic           overtemp_shutdown;
      logic           hw_limit_cmp;
   } gdf_pins_t;

   // Gate-driver fault status word (low bits)
   typedef struct packed {
      logic main_uv;
      logic logic_por;
      logic gate_uv;
      logic boot_uv;
      logic ds_oc;
      logic shunt_oc;
      logic overtemp;
   } gdf_flt_t;

   // Response classes of the current-limit mode field
   typedef enum {IL_OFF, IL_LOW_ON, IL_REPORT, IL_NONE} gdf_il_t;

   // Retry timer states
   typedef enum {RT_IDLE, RT_RUN} gdf_rt_t;

   // Timing base
   localparam int unsigned CLK_NS      = 50;
   localparam int unsigned US_NS       = 1000;
   localparam int unsigned MS_NS       = 1000000;
   localparam int unsigned REPORT_MS   = 200;
   localparam int unsigned US_CYC      = US_NS / CLK_NS;
   localparam int unsigned MS_CYC_DFLT = MS_NS / CLK_NS;

   // Retry time per select code, in ms
   localparam logic [15:0] RETRY_MS [8] = '{
      16'h0064, 16'h00C8, 16'h01F4, 16'h03E8,
      16'h07D0, 16'h0BB8, 16'h1388, 16'h2710};

   // Current-limit deglitch per select code, in us
   localparam logic [7:0] DEG_US [8] = '{
      8'h01, 8'h02, 8'h05, 8'h0A, 8'h14, 8'h32, 8'h64, 8'hC8};

endpackage : gdf_pkg

// ### bench/gdf_fault_checker.sv
// Checker: port-level properties of the fault block
`timescale 1ns/1ns
module gdf_fault_checker (
   // Clock and reset
   input wire logic                    core_clk,
   input wire logic                    rst_n,
   // Watched ports
   input wire gdf_pkg::gdf_pins_t      pins_in,
   input wire logic [gdf_pkg::NPH-1:0] gate_hi,
   input wire logic [gdf_pkg::NPH-1:0] gate_lo,
   input wire logic                    charge_pump_en,
   input wire logic                    logic_en,
   input wire logic                    fault_out_n
);
   import gdf_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // Only these two supplies may stop the pump
   wire sup_ok = !pins_in.main_supply_uv && !pins_in.logic_supply_por;
   // Conditions held past sync and latch delay
   sequence s_main; pins_in.main_supply_uv [*5]; endsequence
   sequence s_por; pins_in.logic_supply_por [*5]; endsequence
   sequence s_gate; (pins_in.gate_supply_uv && sup_ok) [*5]; endsequence
   sequence s_hot; pins_in.overtemp_shutdown [*5]; endsequence
   property p_report;
      $rose(pins_in.overtemp_shutdown) |-> ##[1:6] !fault_out_n;
   endproperty
   a_report: assert property (p_report) else $error("late report");
   property p_main_off;
      s_main |=> !charge_pump_en && !logic_en && !fault_out_n
         && gate_hi == '0;
   endproperty
   a_main_off: assert property (p_main_off) else $error("main uv");
   property p_main_back;
      $fell(pins_in.main_supply_uv) && sup_ok |-> ##[1:6] charge_pump_en;
   endproperty
   a_main_back: assert property (p_main_back) else $error("no auto");
   property p_por_off;
      s_por |=> !logic_en && !charge_pump_en && !fault_out_n;
   endproperty
   a_por_off: assert property (p_por_off) else $error("por on");
   property p_por_back;
      $fell(pins_in.logic_supply_por) && sup_ok |-> ##[1:6] logic_en;
   endproperty
   a_por_back: assert property (p_por_back) else $error("no restart");
   property p_gate;
      s_gate |=> gate_hi == '0 && gate_lo == '0 && !fault_out_n
         && charge_pump_en;
   endproperty
   a_gate: assert property (p_gate) else $error("gate uv");
   property p_hot;
      s_hot |=> gate_hi == '0 && gate_lo == '0 && !fault_out_n;
   endproperty
   a_hot: assert property (p_hot) else $error("overtemp");
   property p_release;
      $rose(fault_out_n) |-> !$past(pins_in.overtemp_shutdown, 3)
         && !$past(pins_in.gate_supply_uv, 3);
   endproperty
   a_release: assert property (p_release) else $error("early free");
endmodule : gdf_fault_checker

bind gdf_fault_prot gdf_fault_checker u_chk (
   .core_clk(core_clk), .rst_n(rst_n), .pins_in(pins_in),
   .gate_hi(gate_hi), .gate_lo(gate_lo), .logic_en(logic_en),
   .charge_pump_en(charge_pump_en), .fault_out_n(fault_out_n));

// ### bench/gdf_bridge_model.sv
// Bridge model: half-bridges whose drain-source monitors see a short
`timescale 1ns/1ns
module gdf_bridge_model (
   // Gate drive from the block
   input  wire logic [gdf_pkg::NPH-1:0] gate_hi,
   input  wire logic [gdf_pkg::NPH-1:0] gate_lo,
   // Load short injected by the bench
   input  wire logic                    short_en,
   // Monitor flags back to the block
   output      logic [gdf_pkg::NPH-1:0] ds_hs,
   output      logic [gdf_pkg::NPH-1:0] ds_ls
);
   import gdf_pkg::*;
   // A switch only drops voltage while it conducts, so a shutdown
   // takes its own flag away; the latch must hold the fault
   assign ds_hs = short_en ? gate_hi : '0;
   assign ds_ls = short_en ? gate_lo : '0;
endmodule : gdf_bridge_model

// ### bench/gdf_fault_prot_tb.sv
// Testbench: fault block driven over APB and comparator pins
`timescale 1ns/1ns
module gdf_fault_prot_tb;
   import gdf_pkg::*;
   localparam int MSC = 20;             // Cycles per ms in sim
   localparam int RTW = 102 * MSC + 10; // Retry code 0 plus slack
   logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic        pump, len, fault_out_n, short_en, err;
   logic [7:0]  paddr, lvl;
   logic [31:0] pwdata, prdata, rd;
   logic [14:0] pv;                     // Pins, package order
   logic [2:0]  pwm_hi, pwm_lo, gate_hi, gate_lo, hs, ls;
   gdf_pins_t   pins;
   int          error_cnt = 0, comparisons = 0, cyc = 0;
   assign pins = {pv[14:9], hs, ls, pv[2:0]};
   gdf_fault_prot #(.MS_CYC(MSC)) dut (.core_clk(core_clk),
      .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .pins_in(pins),
      .pwm_hi(pwm_hi), .pwm_lo(pwm_lo), .gate_hi(gate_hi),
      .gate_lo(gate_lo), .charge_pump_en(pump), .logic_en(len),
      .fault_out_n(fault_out_n), .drain_source_level_sel(lvl[7:4]),
      .hw_current_limit_threshold(lvl[3:0]));
   gdf_bridge_model u_br (.gate_hi(gate_hi), .gate_lo(gate_lo),
      .short_en(short_en), .ds_hs(hs), .ds_ls(ls));
   initial begin
      core_clk = 0;
      forever #25 core_clk = ~core_clk;
   end
   // Hang guard
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         error_cnt++;
         final_report();
      end
   end
   task automatic w(input int n);
      repeat (n) @(posedge core_clk);
   endtask : w
   task automatic chk(input string nm, input logic [31:0] e, g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   // One APB transfer; request held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n = 0;
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) chk("pready", 1, pready);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic regs();
      apb(0, CFG_OFS, 0);
      chk("cfg rst", CFG_RST, rd);
      apb(1, CFG_OFS, 32'hFFFF_FFFF);
      apb(0, CFG_OFS, 0);
      chk("cfg rw", CFG_WMASK, rd);
      chk("sel out", 8'hFF, lvl);
      apb(0, 8'h10, 0);
      chk("unmapped", 32'h0000_0001, {rd[30:0], err});
      apb(1, CFG_OFS, CFG_RST);
      $display("test regs done");
   endtask : regs
   // Trip one source; md 0 latched, 1 retry, 2 automatic
   task automatic flt(input int b, input logic [31:0] cfg,
                      input int md, input logic [31:0] sb);
      apb(1, CFG_OFS, cfg);
      if (b == 15) short_en <= 1'b1;
      else pv[b] <= 1'b1;
      w(8);
      chk("fault pin", 0, fault_out_n);
      chk("gates", 0, {gate_hi, gate_lo});
      apb(0, GSTA_OFS, 0);
      chk("status", sb, rd);
      short_en <= 1'b0;
      pv       <= '0;
      w(8);
      chk("held", md == 2, fault_out_n);
      if (md == 1) w(RTW);
      if (md == 0) begin
         apb(1, CMD_OFS, 1);
         w(6);
      end
      chk("freed", 1, fault_out_n);
      chk("gates back", {pwm_hi, pwm_lo}, {gate_hi, gate_lo});
      $display("test fault %0d mode %0d done", b, md);
   endtask : flt
   task automatic dis();
      apb(1, CFG_OFS, 32'h0000_902C);
      pv[10]   <= 1'b1;
      pv[2]    <= 1'b1;
      short_en <= 1'b1;
      w(10);
      chk("masked", 1, fault_out_n);
      chk("gates run", {pwm_hi, pwm_lo}, {gate_hi, gate_lo});
      pv       <= '0;
      short_en <= 1'b0;
      w(4);
      $display("test disable done");
   endtask : dis
   // Current limit in mode m, deglitch code 0 (1 us)
   task automatic lim(input logic [3:0] m);
      logic off, low, rep;
      off = !m[3];
      rep = m == 4'h8;
      low = off && m[1];
      apb(1, CFG_OFS, {16'h0000, m, 12'h000});
      pv[0] <= 1'b1;
      w(30);
      chk("lim pin", !(off || rep), fault_out_n);
      chk("lim hi", off ? 3'b000 : pwm_hi, gate_hi);
      chk("lim lo", low ? 3'b111 : off ? 3'b000 : pwm_lo, gate_lo);
      apb(0, CSTA_OFS, 0);
      chk("lim sta", (off || rep) ? 3 : 0, rd);
      pv[0] <= 1'b0;
      if (off && m[2]) w(RTW);
      else if (off || rep) begin
         w(4);
         chk("lim hold", 0, fault_out_n);
         apb(1, CMD_OFS, 1);
         w(6);
      end
      chk("lim free", 1, fault_out_n);
      apb(0, CSTA_OFS, 0);
      chk("lim sta0", 0, rd);
      $display("test limit mode %h done", m);
   endtask : lim
   task automatic sup(input int b);
      pv[b] <= 1'b1;
      w(8);
      chk("sup off", 0, {fault_out_n, pump, len, gate_hi});
      pv[b] <= 1'b0;
      w(8);
      chk("sup back", 3'b111, {fault_out_n, pump, len});
      $display("test supply %0d done", b);
   endtask : sup
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : final_report
   initial begin
      rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
      pwdata = 0; pv = 0; short_en = 0; pwm_hi = 3'b001; pwm_lo = 3'b010;
      w(12);
      rst_n <= 1'b1;
      w(2);
      regs();
      flt(12, 32'h0000_9000, 0, 32'h10);
      flt(12, 32'h0000_9001, 1, 32'h10);
      flt(10, 32'h0000_9000, 0, 32'h08);
      flt(10, 32'h0000_9002, 1, 32'h08);
      flt(15, 32'h0000_9000, 0, 32'h04);
      flt(15, 32'h0000_9010, 1, 32'h04);
      flt(2, 32'h0000_9000, 0, 32'h02);
      flt(2, 32'h0000_9040, 1, 32'h02);
      flt(1, 32'h0000_9000, 0, 32'h01);
      flt(1, 32'h0000_9080, 2, 32'h01);
      dis();
      for (int m = 0; m < 16; m++) lim(m[3:0]);
      sup(14);
      sup(13);
      final_report();
   end
endmodule : gdf_fault_prot_tb
